// >>> common/omcs_pkg.sv
package omcs_pkg;
  // two-wire device addresses (7-bit): identification page and diagnostic page
  localparam logic [6:0] DEV_ID_ADDR   = 7'h50;
  localparam logic [6:0] DEV_DIAG_ADDR = 7'h51;
  // control/status byte on the diagnostic page and its fields
  localparam logic [7:0] CS_OFFSET     = 8'h6e;
  localparam int         B_PIN         = 7;
  localparam int         B_SOFT        = 6;
  localparam int         B_FAULT       = 2;
  localparam int         B_LOS         = 1;
  localparam int         B_READY       = 0;
  localparam logic [7:0] ID_READ_VALUE = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] MAX_BURST     = 4'h8;
  // timing in milliseconds as printed, clock rate in kHz
  localparam int CLK_KHZ       = 40000;
  localparam int T_OFF_MS      = 10;
  localparam int T_ON_MS       = 1;
  localparam int T_INIT_MS     = 300;
  localparam int T_FAULT_MS    = 100;
  localparam int T_RESET_MS    = 10;
  localparam int T_LOSS_MS     = 100;
  localparam int T_DATA_MS     = 1000;
  localparam int T_SERIAL_MS   = 300;
  localparam int T_WRITE_MS    = 10;
  localparam int F_SCL_MAX_KHZ = 400;
  // cycle counts derived from the rate
  localparam int RESET_CYC  = T_RESET_MS * CLK_KHZ;
  localparam int DATA_CYC   = T_DATA_MS * CLK_KHZ;
  localparam int SERIAL_CYC = T_SERIAL_MS * CLK_KHZ;
  localparam int WRITE_CYC  = T_WRITE_MS * CLK_KHZ;
  localparam int TW         = 26;
  // two-wire slave states
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ADDR  = 7'h02,
    ST_AACK  = 7'h04,
    ST_WDATA = 7'h08,
    ST_WACK  = 7'h10,
    ST_RDATA = 7'h20,
    ST_RACK  = 7'h40
  } omcs_state_type;
  // synchronised pin levels
  typedef struct packed {
    logic scl;
    logic sda;
    logic laser_off;
    logic fault;
    logic signal_ok;
  } omcs_pins_type;
endpackage

// >>> design/omcs_top.sv
`timescale 1ns/1ps
// Summary of operation
// - laser off within 10 ms of pin rise
// - laser on within 1 ms of pin fall
// - initialise and clear fault within 300 ms
// - fault flag asserted within 100 ms
// - signal lost output rises within 100 ms
// - signal lost output falls within 100 ms
// - soft off bit disables laser after stop
// - clearing soft off bit restores laser
// - fault mirrored in status bit 2
// - signal loss mirrored in status bit 1
// - data ready bit set within 1000 ms
// - serial bus answers within 300 ms
// - write committed within 10 ms of stop
// - signal lost high below sensitivity, else low
module omcs_top #(
  parameter int unsigned RESET_CYCLES  = omcs_pkg::RESET_CYC,
  parameter int unsigned DATA_CYCLES   = omcs_pkg::DATA_CYC,
  parameter int unsigned SERIAL_CYCLES = omcs_pkg::SERIAL_CYC,
  parameter int unsigned WRITE_CYCLES  = omcs_pkg::WRITE_CYC
) (
  // clock, reset, enable
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ce,
  // host pins and internal sense inputs (asynchronous)
  input  wire logic laser_off_request,
  input  wire logic laser_fault_sense,
  input  wire logic signal_ok_sense,
  // two-wire bus
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  // module outputs
  output logic      laser_enable,
  output logic      laser_fault_flag,
  output logic      rx_signal_lost
);
  localparam int TW = omcs_pkg::TW;

  omcs_pkg::omcs_pins_type  meta_ff, sync_ff, last_ff;
  omcs_pkg::omcs_state_type state_ff;
  logic [TW-1:0] por_cnt_ff, hold_cnt_ff, busy_cnt_ff;
  logic [3:0]    bit_cnt_ff, burst_ff;
  logic [7:0]    shift_ff, ptr_ff;
  logic          page_ff, first_ff, ack_ff, wrote_ff, pend_ff, pend_val_ff;
  logic          soft_off_ff, fault_ff, los_ff, ready_ff, serial_rdy_ff;
  logic          sda_oe_ff, laser_en_ff;
  logic [7:0]    diag_mem [0:255];

  // two flops on every asynchronous input; last_ff feeds edge detection only
  omcs_pkg::omcs_pins_type raw;
  assign raw = '{scl: scl_in, sda: sda_in, laser_off: laser_off_request,
                 fault: laser_fault_sense, signal_ok: signal_ok_sense};
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
      last_ff <= '0;
    end else if (ce) begin
      meta_ff <= raw;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // bus conditions seen on the sampled lines
  wire scl_rise  = sync_ff.scl & ~last_ff.scl;
  wire scl_fall  = ~sync_ff.scl & last_ff.scl;
  wire start_c   = sync_ff.scl & last_ff.scl & last_ff.sda & ~sync_ff.sda;
  wire stop_c    = sync_ff.scl & last_ff.scl & ~last_ff.sda & sync_ff.sda;
  wire pin_fall  = ~sync_ff.laser_off & last_ff.laser_off;
  wire byte_done = (bit_cnt_ff == omcs_pkg::BITS_PER_BYTE);
  wire addr_hit  = (shift_ff[7:1] == omcs_pkg::DEV_ID_ADDR) ||
                   (shift_ff[7:1] == omcs_pkg::DEV_DIAG_ADDR);
  wire busy      = (busy_cnt_ff != '0);
  wire is_cs     = page_ff && (ptr_ff == omcs_pkg::CS_OFFSET);
  wire burst_ok  = (burst_ff < omcs_pkg::MAX_BURST);
  wire mem_we    = ce && !rst && (state_ff == omcs_pkg::ST_WDATA) && scl_fall &&
                   byte_done && !first_ff && burst_ok && page_ff && !is_cs;

  // status byte; unused bits read zero
  wire [7:0] status_byte = {sync_ff.laser_off, soft_off_ff, 3'h0, fault_ff, los_ff, ready_ff};

  // byte returned for the current pointer; identification page is not stored here
  function automatic logic [7:0] read_byte(input logic pg, input logic cs, input logic [7:0] st,
                                           input logic [7:0] mem);
    if (!pg) begin
      read_byte = omcs_pkg::ID_READ_VALUE;
    end else if (cs) begin
      read_byte = st;
    end else begin
      read_byte = mem;
    end
  endfunction
  wire [7:0] rd_byte = read_byte(page_ff, is_cs, status_byte, diag_mem[ptr_ff]);

  // power-on timers: bus readiness and analog data ready
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      por_cnt_ff    <= '0;
      serial_rdy_ff <= 1'b0;
      ready_ff      <= 1'b0;
    end else if (ce) begin
      if (por_cnt_ff != TW'(DATA_CYCLES)) begin
        por_cnt_ff <= por_cnt_ff + 1'b1;
      end
      if (por_cnt_ff >= TW'(SERIAL_CYCLES - 1)) begin
        serial_rdy_ff <= 1'b1;
      end
      if (por_cnt_ff >= TW'(DATA_CYCLES - 1)) begin
        ready_ff <= 1'b1;
      end
    end
  end

  // how long the disable pin has been high, saturating at the reset time
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_cnt_ff <= '0;
    end else if (ce) begin
      if (!sync_ff.laser_off) begin
        hold_cnt_ff <= '0;
      end else if (hold_cnt_ff != TW'(RESET_CYCLES)) begin
        hold_cnt_ff <= hold_cnt_ff + 1'b1;
      end
    end
  end

  // laser fault latch and signal loss; a live fault wins over the reset pulse
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_ff <= 1'b0;
      los_ff   <= 1'b1;
    end else if (ce) begin
      if (sync_ff.fault) begin
        fault_ff <= 1'b1;
      end else if (pin_fall && hold_cnt_ff == TW'(RESET_CYCLES)) begin
        fault_ff <= 1'b0;
      end
      los_ff <= ~sync_ff.signal_ok;
    end
  end

  // laser drive: any disable source or a latched fault keeps it dark
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      laser_en_ff <= 1'b0;
    end else if (ce) begin
      laser_en_ff <= ~sync_ff.laser_off & ~soft_off_ff & ~fault_ff;
    end
  end

  // diagnostic page storage; the array has no reset, contents are undefined at power-up
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      diag_mem[ptr_ff] <= shift_ff;
    end
  end

  // write-cycle busy timer; address is refused while it runs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_cnt_ff <= '0;
      soft_off_ff <= 1'b0;
    end else if (ce) begin
      if (stop_c && wrote_ff) begin
        busy_cnt_ff <= TW'(WRITE_CYCLES);
        if (pend_val_ff) begin
          soft_off_ff <= pend_ff;
        end
      end else if (busy) begin
        busy_cnt_ff <= busy_cnt_ff - 1'b1;
      end
    end
  end

  // two-wire slave: sample on scl rise, change sda on scl fall
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff    <= omcs_pkg::ST_IDLE;
      bit_cnt_ff  <= '0;
      burst_ff    <= '0;
      shift_ff    <= '0;
      ptr_ff      <= '0;
      page_ff     <= 1'b0;
      first_ff    <= 1'b0;
      ack_ff      <= 1'b0;
      wrote_ff    <= 1'b0;
      pend_ff     <= 1'b0;
      pend_val_ff <= 1'b0;
      sda_oe_ff   <= 1'b0;
    end else if (ce) begin
      if (start_c) begin
        state_ff    <= omcs_pkg::ST_ADDR;
        bit_cnt_ff  <= '0;
        sda_oe_ff   <= 1'b0;
        wrote_ff    <= 1'b0;
        pend_val_ff <= 1'b0;
      end else if (stop_c) begin
        state_ff  <= omcs_pkg::ST_IDLE;
        sda_oe_ff <= 1'b0;
        wrote_ff  <= 1'b0;
      end else if (scl_rise) begin
        case (state_ff)
          omcs_pkg::ST_ADDR, omcs_pkg::ST_WDATA: begin
            shift_ff   <= {shift_ff[6:0], sync_ff.sda};
            bit_cnt_ff <= bit_cnt_ff + 1'b1;
          end
          omcs_pkg::ST_RDATA: begin
            bit_cnt_ff <= bit_cnt_ff + 1'b1;
          end
          omcs_pkg::ST_RACK: begin
            ack_ff <= ~sync_ff.sda;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state_ff)
          omcs_pkg::ST_ADDR: begin
            if (byte_done) begin
              if (addr_hit && serial_rdy_ff && !busy) begin
                state_ff  <= omcs_pkg::ST_AACK;
                sda_oe_ff <= 1'b1;
                page_ff   <= shift_ff[1];
                ack_ff    <= shift_ff[0];
              end else begin
                state_ff <= omcs_pkg::ST_IDLE;
              end
            end
          end
          omcs_pkg::ST_AACK: begin
            bit_cnt_ff <= '0;
            burst_ff   <= '0;
            if (ack_ff) begin
              state_ff  <= omcs_pkg::ST_RDATA;
              sda_oe_ff <= ~rd_byte[7];
              shift_ff  <= {rd_byte[6:0], 1'b0};
            end else begin
              state_ff  <= omcs_pkg::ST_WDATA;
              sda_oe_ff <= 1'b0;
              first_ff  <= 1'b1;
            end
          end
          omcs_pkg::ST_WDATA: begin
            if (byte_done) begin
              state_ff  <= omcs_pkg::ST_WACK;
              sda_oe_ff <= first_ff | burst_ok;
              first_ff  <= 1'b0;
              if (first_ff) begin
                ptr_ff <= shift_ff;
              end else if (burst_ok) begin
                ptr_ff   <= ptr_ff + 8'h01;
                burst_ff <= burst_ff + 1'b1;
                wrote_ff <= 1'b1;
                if (is_cs) begin
                  pend_ff     <= shift_ff[omcs_pkg::B_SOFT];
                  pend_val_ff <= 1'b1;
                end
              end
            end
          end
          omcs_pkg::ST_WACK: begin
            state_ff   <= omcs_pkg::ST_WDATA;
            sda_oe_ff  <= 1'b0;
            bit_cnt_ff <= '0;
          end
          omcs_pkg::ST_RDATA: begin
            if (byte_done) begin
              state_ff  <= omcs_pkg::ST_RACK;
              sda_oe_ff <= 1'b0;
              ptr_ff    <= ptr_ff + 8'h01;
            end else begin
              sda_oe_ff <= ~shift_ff[7];
              shift_ff  <= {shift_ff[6:0], 1'b0};
            end
          end
          omcs_pkg::ST_RACK: begin
            bit_cnt_ff <= '0;
            if (ack_ff) begin
              state_ff  <= omcs_pkg::ST_RDATA;
              sda_oe_ff <= ~rd_byte[7];
              shift_ff  <= {rd_byte[6:0], 1'b0};
            end else begin
              state_ff <= omcs_pkg::ST_IDLE;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // open-drain data: only ever pulls low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sda_out <= 1'b0;
    end else if (ce) begin
      sda_out <= 1'b0;
    end
  end

  assign sda_oe           = sda_oe_ff;
  assign laser_enable     = laser_en_ff;
  assign laser_fault_flag = fault_ff;
  assign rx_signal_lost   = los_ff;
endmodule

// >>> sim/omcs_checker.sv
`timescale 1ns/1ps
module omcs_checker #(
  parameter int unsigned SERIAL_CYCLES = 100
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // sense inputs
  input wire logic laser_off_request,
  input wire logic laser_fault_sense,
  input wire logic signal_ok_sense,
  // outputs
  input wire logic sda_oe,
  input wire logic laser_enable,
  input wire logic laser_fault_flag,
  input wire logic rx_signal_lost
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [31:0] up_ff;
  // cycles since reset, saturating so it never wraps back into the quiet window
  always_ff @(posedge clk_sys) begin
    if (rst)
      up_ff <= 32'h0;
    else if (up_ff < SERIAL_CYCLES)
      up_ff <= up_ff + 32'h1;
  end
  sequence s_pin_held; laser_off_request[*8]; endsequence
  sequence s_ok_held; signal_ok_sense[*8]; endsequence
  property p_pin_off; $rose(laser_off_request) |-> ##[1:6] !laser_enable; endproperty
  property p_pin_level; s_pin_held |-> !laser_enable; endproperty
  property p_fault_set; $rose(laser_fault_sense) |-> ##[1:5] laser_fault_flag; endproperty
  property p_fault_laser; laser_fault_flag[*2] |-> !laser_enable; endproperty
  // a fault only clears after the pin has been high and fallen
  property p_fault_hold;
    laser_fault_flag && !laser_off_request && !$past(laser_off_request, 5) |=> laser_fault_flag;
  endproperty
  property p_loss_on; $fell(signal_ok_sense) |-> ##[1:5] rx_signal_lost; endproperty
  property p_loss_off; $rose(signal_ok_sense) |-> ##[1:5] !rx_signal_lost; endproperty
  property p_loss_level; s_ok_held |-> !rx_signal_lost; endproperty
  property p_serial_quiet; (up_ff + 32'h2 < SERIAL_CYCLES) |-> !sda_oe; endproperty
  a_pin_off: assert property (p_pin_off) else $error("laser still on after pin rise");
  a_pin_level: assert property (p_pin_level) else $error("laser on with pin high");
  a_fault_set: assert property (p_fault_set) else $error("fault flag late");
  a_fault_laser: assert property (p_fault_laser) else $error("laser on during fault");
  a_fault_hold: assert property (p_fault_hold) else $error("fault flag lost");
  a_loss_on: assert property (p_loss_on) else $error("signal lost output late");
  a_loss_off: assert property (p_loss_off) else $error("signal lost output stuck");
  a_loss_level: assert property (p_loss_level) else $error("signal lost while valid");
  a_serial_quiet: assert property (p_serial_quiet) else $error("bus answered too early");
endmodule

bind omcs_top omcs_checker #(.SERIAL_CYCLES(SERIAL_CYCLES)) i_omcs_checker (
  .clk_sys(clk_sys), .rst(rst), .laser_off_request(laser_off_request),
  .laser_fault_sense(laser_fault_sense), .signal_ok_sense(signal_ok_sense),
  .sda_oe(sda_oe), .laser_enable(laser_enable), .laser_fault_flag(laser_fault_flag),
  .rx_signal_lost(rx_signal_lost));

// >>> sim/omcs_host.sv
`timescale 1ns/1ps
module omcs_host (
  // two-wire bus, data pulled up
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // data moves only while the clock is low except at start and stop, clock stands high between frames
  // bit period scaled down with the timers
  task automatic put_bit(input logic b, output logic r);
    scl = 1'b0;
    #25 sda_low = ~b;
    #75 scl = 1'b1;
    #50 r = sda;
    #50;
  endtask
  // the sampled bit is discarded so the data line is written once per step
  task automatic start();
    logic d;
    put_bit(1'b1, d);
    sda_low = 1'b1;
    #100;
  endtask
  task automatic stop();
    logic d;
    put_bit(1'b0, d);
    sda_low = 1'b0;
    #100;
  endtask
  // msb first, ninth bit is the acknowledge
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--)
      put_bit(tx[i], rx[i]);
    put_bit(last, ack);
  endtask
endmodule

// >>> sim/test_omcs_top.sv
`timescale 1ns/1ps
module test_omcs_top;
  logic       clk_sys;
  logic       rst;
  logic       ce;
  logic       laser_off_request;
  logic       laser_fault_sense;
  logic       signal_ok_sense;
  logic       scl;
  logic       host_low;
  logic       sda_out;
  logic       sda_oe;
  logic       laser_enable;
  logic       laser_fault_flag;
  logic       rx_signal_lost;
  logic       ack;
  logic [7:0] rd;
  wire        sda_wire;
  int         miscompares;
  int         checks;
  // open-drain data line with pull-up
  assign sda_wire = !(host_low || sda_oe);
  omcs_top #(.RESET_CYCLES(20), .DATA_CYCLES(400), .SERIAL_CYCLES(100), .WRITE_CYCLES(200))
    i_omcs_top (.clk_sys(clk_sys), .rst(rst), .ce(ce), .laser_off_request(laser_off_request),
    .laser_fault_sense(laser_fault_sense), .signal_ok_sense(signal_ok_sense), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .laser_enable(laser_enable),
    .laser_fault_flag(laser_fault_flag), .rx_signal_lost(rx_signal_lost));
  omcs_host i_omcs_host (.scl(scl), .sda_low(host_low), .sda(sda_wire));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // write one data byte; ack returns the address acknowledge level
  task automatic wr(input logic [7:0] dev, input logic [7:0] d);
    logic [7:0] x;
    logic       a;
    i_omcs_host.start();
    i_omcs_host.xfer(dev, 1'b1, x, ack);
    i_omcs_host.xfer(omcs_pkg::CS_OFFSET, 1'b1, x, a);
    i_omcs_host.xfer(d, 1'b1, x, a);
    i_omcs_host.stop();
  endtask
  // pointer write, repeated start, one byte read with no acknowledge
  task automatic rd_cs(input logic [7:0] exp);
    logic [7:0] x;
    logic       a;
    i_omcs_host.start();
    i_omcs_host.xfer(8'ha2, 1'b1, x, a);
    i_omcs_host.xfer(omcs_pkg::CS_OFFSET, 1'b1, x, a);
    i_omcs_host.start();
    i_omcs_host.xfer(8'ha3, 1'b1, x, a);
    i_omcs_host.xfer(8'hff, 1'b1, rd, a);
    i_omcs_host.stop();
    cmp(rd, exp);
  endtask
  task automatic summarize();
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_sys);
    miscompares++;
    summarize();
  end
  initial begin
    {rst, ce, laser_off_request, laser_fault_sense, signal_ok_sense} = 5'h19;
    miscompares = 0;
    checks = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    wr(8'ha2, 8'h40); cmp({7'h0, ack}, 8'h01);
    pause(400);
    wr(8'ha4, 8'h40); cmp({7'h0, ack}, 8'h01);
    rd_cs(8'h01);
    wr(8'ha2, 8'h40); cmp({7'h0, ack}, 8'h00);
    pause(3); cmp({7'h0, laser_enable}, 8'h00);
    // early second write must be refused while committing
    wr(8'ha2, 8'h00); cmp({7'h0, ack}, 8'h01);
    pause(200);
    rd_cs(8'h41);
    wr(8'ha2, 8'h00);
    pause(5); cmp({7'h0, laser_enable}, 8'h01);
    pause(200);
    @(posedge clk_sys) laser_off_request <= 1'b1;
    pause(8); cmp({7'h0, laser_enable}, 8'h00);
    rd_cs(8'h81);
    @(posedge clk_sys) laser_off_request <= 1'b0;
    pause(8); cmp({7'h0, laser_enable}, 8'h01);
    @(posedge clk_sys) laser_fault_sense <= 1'b1;
    pause(8); cmp({6'h0, laser_fault_flag, laser_enable}, 8'h02);
    @(posedge clk_sys) laser_fault_sense <= 1'b0;
    rd_cs(8'h05);
    // a pulse shorter than the reset hold leaves the fault latched
    @(posedge clk_sys) laser_off_request <= 1'b1;
    pause(10);
    @(posedge clk_sys) laser_off_request <= 1'b0;
    pause(10); cmp({7'h0, laser_fault_flag}, 8'h01);
    @(posedge clk_sys) laser_off_request <= 1'b1;
    pause(30);
    @(posedge clk_sys) laser_off_request <= 1'b0;
    pause(10); cmp({6'h0, laser_fault_flag, laser_enable}, 8'h01);
    @(posedge clk_sys) signal_ok_sense <= 1'b0;
    pause(8); cmp({7'h0, rx_signal_lost}, 8'h01);
    rd_cs(8'h03);
    @(posedge clk_sys) signal_ok_sense <= 1'b1;
    pause(8); cmp({7'h0, rx_signal_lost}, 8'h00);
    rd_cs(8'h01);
    summarize();
  end
endmodule
